// ### common/sst_defs.vh
// constants for the swap / skip / table-read / xor execution block
// assumes inclusion by bare name from design files under logic/
`ifndef SST_DEFS_VH
`define SST_DEFS_VH

// operation select codes on op_code
`define SST_OP_NONE   4'h0
`define SST_OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR  4'h1
`define SST_OP_SKZ    4'h2
`define SST_OP_SKZA   4'h3
`define SST_OP_SKBIT  4'h4
`define SST_OP_TRDC   4'h5
`define SST_OP_TRDL   4'h6
`define SST_OP_XORA   4'h7
`define SST_OP_EXCLUSIVE_OR_INTO_MEMORY   4'h8
`define SST_OP_XORI   4'h9

// widths
`define SST_PC_W      11
`define SST_PAGE_W    3
// last program page number (2k words of 256)
`define SST_LAST_PAGE 3'h7

// reset values
`define SST_ACC_RST   8'h00
`define SST_TABLE_HIGH_LATCH_RST  8'h00
`define SST_ZF_RST    1'b0

// table read occupies this many machine cycles
`define SST_TRD_CYCLES 2

`endif

// ### logic/sst_alu.v
// combinational result unit: swap, xor, zero tests
// assumes operands stable for the cycle they are used
`timescale 1ns/1ps
`include "sst_defs.vh"

module sst_alu (
  input wire [3:0] op_code,
  input wire [7:0] acc,
  input wire [7:0] mem_data,
  input wire [7:0] imm_data,
  input wire [2:0] bit_sel,
  output reg [7:0] result,
  output reg skip_cond,
  output wire res_zero
);
  // result and skip condition per operation
  always @* begin
    result = acc;
    skip_cond = 1'b0;
    case (op_code)
      `SST_OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR: result = {mem_data[3:0], mem_data[7:4]};
      `SST_OP_SKZ: skip_cond = (mem_data == 8'h00);
      `SST_OP_SKZA: begin
        result = mem_data;
        skip_cond = (mem_data == 8'h00);
      end
      `SST_OP_SKBIT: skip_cond = ~mem_data[bit_sel];
      `SST_OP_XORA, `SST_OP_EXCLUSIVE_OR_INTO_MEMORY: result = acc ^ mem_data;
      `SST_OP_XORI: result = acc ^ imm_data;
      default: result = acc;
    endcase
  end

  assign res_zero = (result == 8'h00);
endmodule // sst_alu

// ### logic/sst_exec.v
// execution unit for swap, skip, table read and xor operations
// assumes the core presents one decoded op per machine cycle on op_valid,
// and that program memory answers a read in the same cycle (rom_data)
// limitation: carry and the other flags except zero live outside this block
`timescale 1ns/1ps
`include "sst_defs.vh"

module sst_exec (
  input wire core_clk,
  input wire reset,
  input wire op_valid,
  input wire [3:0] op_code,
  input wire [7:0] mem_data,
  input wire [7:0] mem_addr,
  input wire [7:0] imm_data,
  input wire [2:0] bit_sel,
  input wire [7:0] table_pointer,
  input wire [10:0] cur_pc,
  input wire [15:0] rom_data,
  output wire busy,
  output wire rom_rd,
  output wire [10:0] rom_addr,
  output reg [7:0] acc_q,
  output reg zero_flag_q,
  output reg [7:0] table_high_latch_q,
  output reg mem_wr_q,
  output reg [7:0] mem_wr_addr_q,
  output reg [7:0] mem_wr_data_q,
  output reg skip_next_q,
  output reg dummy_cycle_q
);
  localparam ST_IDLE = 2'h0;
  localparam ST_DUMMY = 2'h1;
  localparam ST_TRD = 2'h2;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [7:0] trd_addr_q;
  reg [2:0] trd_page_q;
  wire [7:0] alu_res;
  wire alu_skip;
  wire alu_zero;
  wire is_trd;

  sst_alu u_alu (
    .op_code(op_code),
    .acc(acc_q),
    .mem_data(mem_data),
    .imm_data(imm_data),
    .bit_sel(bit_sel),
    .result(alu_res),
    .skip_cond(alu_skip),
    .res_zero(alu_zero)
  );

  assign is_trd = (op_code == `SST_OP_TRDC) || (op_code == `SST_OP_TRDL);
  // new ops are refused while a dummy or table cycle is in progress
  assign busy = (state_q != ST_IDLE);
  // rom read happens in the second cycle of a table read
  assign rom_rd = (state_q == ST_TRD);
  // page from pc or last page, word from pointer
  assign rom_addr = {trd_page_q, table_pointer};

  // next state
  always @* begin
    state_d = ST_IDLE;
    case (state_q)
      ST_IDLE: begin
        if (op_valid && is_trd) begin
          state_d = ST_TRD;
        end else if (op_valid && alu_skip) begin
          state_d = ST_DUMMY;
        end
      end
      ST_DUMMY: state_d = ST_IDLE;
      ST_TRD: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // decoded take strobes; nothing is taken while busy
  wire op_take;
  wire take_swap;
  wire take_skza;
  wire take_xor_acc;
  wire take_exclusive_or_into_memory;
  wire take_trdc;
  wire take_trdl;
  wire take_skip;
  // next values of the registered outputs
  reg [7:0] acc_d;
  reg zero_flag_d;
  reg [7:0] table_high_latch_d;
  reg mem_wr_d;
  reg [7:0] mem_wr_addr_d;
  reg [7:0] mem_wr_data_d;
  reg skip_next_d;
  reg dummy_cycle_d;
  reg [7:0] trd_addr_d;
  reg [2:0] trd_page_d;

  // op decode, gated by the idle state so refused ops leave no trace
  assign op_take = op_valid && (state_q == ST_IDLE);
  assign take_swap = op_take && (op_code == `SST_OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR);
  assign take_skza = op_take && (op_code == `SST_OP_SKZA);
  assign take_xor_acc = op_take && ((op_code == `SST_OP_XORA) || (op_code == `SST_OP_XORI));
  assign take_exclusive_or_into_memory = op_take && (op_code == `SST_OP_EXCLUSIVE_OR_INTO_MEMORY);
  assign take_trdc = op_take && (op_code == `SST_OP_TRDC);
  assign take_trdl = op_take && (op_code == `SST_OP_TRDL);
  // table ops never request a skip
  assign take_skip = op_take && alu_skip && !is_trd;

  // accumulator next value; skz, skbit, table and memory xor leave it alone
  always @* begin
    // hold unless an acc-writing op is taken
    acc_d = acc_q;
    if (take_swap || take_skza) begin
      acc_d = alu_res;
    end
    if (take_xor_acc) begin
      acc_d = alu_res;
    end
  end

  // zero flag: only the xor group writes it
  always @* begin
    // hold; swap, skip and table ops keep every flag
    zero_flag_d = zero_flag_q;
    if (take_xor_acc || take_exclusive_or_into_memory) begin
      zero_flag_d = alu_zero;
    end
  end

  // memory write port; address and data hold between pulses
  always @* begin
    mem_wr_d = 1'b0;
    mem_wr_addr_d = mem_wr_addr_q;
    mem_wr_data_d = mem_wr_data_q;
    // the two sources never coincide: a table cycle is busy
    // xor result back to memory
    if (take_exclusive_or_into_memory) begin
      mem_wr_d = 1'b1;
      mem_wr_addr_d = mem_addr;
      mem_wr_data_d = alu_res;
    end
    if (state_q == ST_TRD) begin
      mem_wr_d = 1'b1;
      mem_wr_addr_d = trd_addr_q;
      mem_wr_data_d = rom_data[7:0];
    end
  end

  // table-high latch holds until the next table read
  always @* begin
    table_high_latch_d = table_high_latch_q;
    if (state_q == ST_TRD) begin
      table_high_latch_d = rom_data[15:8];
    end
  end

  // table read capture: target address and page
  always @* begin
    trd_addr_d = trd_addr_q;
    trd_page_d = trd_page_q;
    // page is frozen at take so a pc step cannot move the read
    // current page from pc
    if (take_trdc) begin
      trd_addr_d = mem_addr;
      trd_page_d = cur_pc[10:8];
    end
    if (take_trdl) begin
      trd_addr_d = mem_addr;
      trd_page_d = `SST_LAST_PAGE;
    end
  end

  // skip request and dummy marker
  always @* begin
    skip_next_d = take_skip;
    dummy_cycle_d = (state_d == ST_DUMMY);
  end

  // state register
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // accumulator register
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      acc_q <= `SST_ACC_RST;
    end else begin
      acc_q <= acc_d;
    end
  end

  // zero flag register
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      zero_flag_q <= `SST_ZF_RST;
    end else begin
      zero_flag_q <= zero_flag_d;
    end
  end

  // table-high latch register
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      table_high_latch_q <= `SST_TABLE_HIGH_LATCH_RST;
    end else begin
      table_high_latch_q <= table_high_latch_d;
    end
  end

  // memory write strobe, one cycle wide
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mem_wr_q <= 1'b0;
    end else begin
      mem_wr_q <= mem_wr_d;
    end
  end

  // memory write address
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mem_wr_addr_q <= 8'h00;
    end else begin
      mem_wr_addr_q <= mem_wr_addr_d;
    end
  end

  // memory write data
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mem_wr_data_q <= 8'h00;
    end else begin
      mem_wr_data_q <= mem_wr_data_d;
    end
  end

  // skip request pulse to the fetch side
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      skip_next_q <= 1'b0;
    end else begin
      skip_next_q <= skip_next_d;
    end
  end

  // dummy cycle marker
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dummy_cycle_q <= 1'b0;
    end else begin
      dummy_cycle_q <= dummy_cycle_d;
    end
  end

  // table read target address
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      trd_addr_q <= 8'h00;
    end else begin
      trd_addr_q <= trd_addr_d;
    end
  end

  // table read page
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      trd_page_q <= 3'h0;
    end else begin
      trd_page_q <= trd_page_d;
    end
  end
endmodule // sst_exec

// ### tb/sst_exec_checker.sv
// port assertions for the execution block
// assumes bound to sst_exec with one clock domain
`timescale 1ns/1ps
`include "sst_defs.vh"
module sst_exec_checker (
  input logic core_clk, reset, op_valid, busy, rom_rd, mem_wr_q, skip_next_q, dummy_cycle_q, zero_flag_q,
  input logic [3:0] op_code,
  input logic [7:0] mem_data, imm_data, table_pointer, acc_q, mem_wr_data_q,
  input logic [2:0] bit_sel,
  input logic [10:0] cur_pc, rom_addr
);
  // op accepted at this edge
  wire tk = op_valid && !busy;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  AST_SWAP: assert property (tk && op_code == `SST_OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR |=>
    acc_q == {$past(mem_data[3:0]), $past(mem_data[7:4])} && $stable(zero_flag_q)) else $error("swap");
  AST_SKZ: assert property (tk && op_code == `SST_OP_SKZ |=>
    skip_next_q == ($past(mem_data) == 8'h00) && busy == skip_next_q) else $error("skip zero");
  AST_SKZA: assert property (tk && op_code == `SST_OP_SKZA |=>
    acc_q == $past(mem_data) && skip_next_q == (acc_q == 8'h00)) else $error("skip copy");
  AST_SKBIT: assert property (tk && op_code == `SST_OP_SKBIT |=>
    skip_next_q == !$past(mem_data[bit_sel])) else $error("bit skip");
  AST_DUMMY: assert property (skip_next_q |-> dummy_cycle_q && busy ##1 !busy) else $error("dummy");
  AST_TRD: assert property (tk && (op_code == `SST_OP_TRDC || op_code == `SST_OP_TRDL) |=>
    rom_rd && rom_addr == {($past(op_code) == `SST_OP_TRDL ? `SST_LAST_PAGE : $past(cur_pc[10:8])),
    $past(table_pointer)} ##1 mem_wr_q) else $error("table read");
  AST_XOR: assert property (tk && (op_code == `SST_OP_XORA || op_code == `SST_OP_XORI) |=>
    acc_q == ($past(acc_q) ^ ($past(op_code) == `SST_OP_XORA ? $past(mem_data) : $past(imm_data)))
    && zero_flag_q == (acc_q == 8'h00)) else $error("xor acc");
  AST_EXCLUSIVE_OR_INTO_MEMORY: assert property (tk && op_code == `SST_OP_EXCLUSIVE_OR_INTO_MEMORY |=>
    mem_wr_q && mem_wr_data_q == ($past(acc_q) ^ $past(mem_data)) && $stable(acc_q)) else $error("xor mem");
  AST_REFUSE: assert property (dummy_cycle_q && op_valid |=>
    $stable(acc_q) && $stable(zero_flag_q) && !mem_wr_q) else $error("refused op acted");
endmodule // sst_exec_checker

// ### tb/sst_exec_tb_top.sv
// self-checking bench for the execution block
// assumes a rom that answers combinationally from rom_addr
`timescale 1ns/1ps
`include "sst_defs.vh"
module sst_exec_tb_top;
  logic core_clk = 0, reset = 1, op_valid = 0;
  logic [3:0] op_code = 0;
  logic [7:0] mem_data = 0, mem_addr = 8'h11, imm_data = 0, table_pointer = 8'h3C;
  logic [2:0] bit_sel = 0;
  logic [10:0] cur_pc = 11'h2A5;
  wire [15:0] rom_data;
  wire busy, rom_rd, mem_wr_q, skip_next_q, dummy_cycle_q, zero_flag_q;
  wire [10:0] rom_addr;
  wire [7:0] acc_q, table_high_latch_q, mem_wr_addr_q, mem_wr_data_q;
  int fail_count = 0, samples_checked = 0;
  // rom word mixes every address bit so a wrong page shows
  assign rom_data = {5'h00, rom_addr} ^ 16'hC35A;
  always #20 core_clk = ~core_clk;
  sst_exec dut (
    .core_clk(core_clk),
    .reset(reset),
    .op_valid(op_valid),
    .op_code(op_code),
    .mem_data(mem_data),
    .mem_addr(mem_addr),
    .imm_data(imm_data),
    .bit_sel(bit_sel),
    .table_pointer(table_pointer),
    .cur_pc(cur_pc),
    .rom_data(rom_data),
    .busy(busy),
    .rom_rd(rom_rd),
    .rom_addr(rom_addr),
    .acc_q(acc_q),
    .zero_flag_q(zero_flag_q),
    .table_high_latch_q(table_high_latch_q),
    .mem_wr_q(mem_wr_q),
    .mem_wr_addr_q(mem_wr_addr_q),
    .mem_wr_data_q(mem_wr_data_q),
    .skip_next_q(skip_next_q),
    .dummy_cycle_q(dummy_cycle_q)
  );
  task chk(string n, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // one op for one cycle; returns just after the answer edge
  task run(logic [3:0] c, logic [7:0] m);
    @(posedge core_clk);
    #1;
    op_valid = 1;
    op_code = c;
    mem_data = m;
    @(posedge core_clk);
    #1;
    op_valid = 0;
  endtask
  task t_alu;
    imm_data = 8'hFF;
    run(`SST_OP_XORI, 8'h00);
    chk("acc", 8'hFF, acc_q);
    chk("zf", 0, zero_flag_q);
    run(`SST_OP_XORI, 8'h00);
    chk("acc", 8'h00, acc_q);
    chk("zf", 1, zero_flag_q);
    run(`SST_OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR, 8'hA5);
    chk("acc", 8'h5A, acc_q);
    chk("zf", 1, zero_flag_q);
    run(`SST_OP_XORA, 8'h0F);
    chk("acc", 8'h55, acc_q);
    chk("zf", 0, zero_flag_q);
    run(`SST_OP_EXCLUSIVE_OR_INTO_MEMORY, 8'h55);
    chk("wr", 8'h01, {7'h00, mem_wr_q});
    chk("data", 8'h00, mem_wr_data_q);
    chk("waddr", 8'h11, mem_wr_addr_q);
    chk("acc", 8'h55, acc_q);
    chk("zf", 1, zero_flag_q);
    $display("alu done");
  endtask
  task t_skip;
    // taken skip, then an xor offered in the dummy cycle must be refused
    @(posedge core_clk);
    #1;
    op_valid = 1;
    op_code = `SST_OP_SKZ;
    mem_data = 8'h00;
    @(posedge core_clk);
    #1;
    op_code = `SST_OP_XORI;
    chk("skip", 3, {6'h00, skip_next_q, dummy_cycle_q});
    chk("busy", 1, busy);
    @(posedge core_clk);
    #1;
    op_valid = 0;
    chk("busy", 0, busy);
    chk("acc", 8'h55, acc_q);
    run(`SST_OP_SKZ, 8'h01);
    chk("skip", 0, {6'h00, skip_next_q, busy});
    run(`SST_OP_SKZA, 8'h00);
    chk("acc", 0, acc_q);
    chk("skip", 1, skip_next_q);
    bit_sel = 3'h7;
    run(`SST_OP_SKBIT, 8'h7F);
    chk("skip", 1, skip_next_q);
    run(`SST_OP_SKBIT, 8'h80);
    chk("skip", 0, skip_next_q);
    run(`SST_OP_SKZA, 8'h80);
    chk("acc", 8'h80, acc_q);
    chk("skip", 0, skip_next_q);
    $display("skip done");
  endtask
  task t_trd;
    logic [10:0] a;
    logic [7:0] w;
    for (int k = 0; k < 2; k++) begin
      a = {(k ? `SST_LAST_PAGE : cur_pc[10:8]), table_pointer};
      w = k ? 8'h42 : 8'h41;
      mem_addr = w;
      run(k ? `SST_OP_TRDL : `SST_OP_TRDC, 8'h00);
      chk("rd", 8'h01, {7'h00, rom_rd});
      chk("page", a[10:8], rom_addr[10:8]);
      @(posedge core_clk);
      #1;
      chk("wr", 8'h01, {7'h00, mem_wr_q});
      chk("waddr", w, mem_wr_addr_q);
      chk("low", a[7:0] ^ 8'h5A, mem_wr_data_q);
      chk("high", {5'h00, a[10:8]} ^ 8'hC3, table_high_latch_q);
    end
    $display("table done");
  endtask
  task finish_test;
    $display("checks %0d bad %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    #1;
    reset = 0;
    t_alu;
    t_skip;
    t_trd;
    finish_test;
  end
endmodule // sst_exec_tb_top
bind sst_exec sst_exec_checker chk_i (
  .core_clk(core_clk),
  .reset(reset),
  .op_valid(op_valid),
  .busy(busy),
  .rom_rd(rom_rd),
  .mem_wr_q(mem_wr_q),
  .skip_next_q(skip_next_q),
  .dummy_cycle_q(dummy_cycle_q),
  .zero_flag_q(zero_flag_q),
  .op_code(op_code),
  .mem_data(mem_data),
  .imm_data(imm_data),
  .table_pointer(table_pointer),
  .acc_q(acc_q),
  .mem_wr_data_q(mem_wr_data_q),
  .bit_sel(bit_sel),
  .cur_pc(cur_pc),
  .rom_addr(rom_addr)
);
